// ===== design/afp_cfg.svh
`ifndef AFP_CFG_SVH
`define AFP_CFG_SVH

// Register byte offsets on the APB
`define AFP_OFF_CTRL    12'h000
`define AFP_OFF_BANK    12'h004
`define AFP_OFF_ACCUM   12'h008
`define AFP_OFF_STATUS  12'h00C
`define AFP_OFF_INSTR   12'h010
`define AFP_OFF_INDEX   12'h014
`define AFP_OFF_MADDR   12'h018
`define AFP_OFF_MDATA   12'h01C

// Field positions
`define AFP_CTRL_EXT    0
`define AFP_STAT_C      0
`define AFP_STAT_DC     1
`define AFP_STAT_Z      2
`define AFP_STAT_OV     3
`define AFP_STAT_N      4
`define AFP_STAT_BUSY   8
`define AFP_STAT_BADOP  9
`define AFP_BANK_BITS   3:0
`define AFP_BYTE_BITS   7:0
`define AFP_ADDR_BITS   11:0
`define AFP_WORD_BITS   15:0
`define AFP_BANK_FIELD  11:8
`define AFP_NIB_BITS    3:0
`define AFP_NIB_CARRY   4
`define AFP_SUM_CARRY   8
`define AFP_SIGN        7

// Instruction encodings
`define AFP_OPC_LIT_BITS 15:8
`define AFP_OPC_REG_BITS 15:10
`define AFP_OPC_ADDL    8'h0F
`define AFP_OPC_ADDF    6'h09
`define AFP_BIT_D       9
`define AFP_BIT_A       8

// Addressing
`define AFP_IDX_LIMIT   8'h5F
`define AFP_ACC_SPLIT   8'h60
`define AFP_ACC_LO_BANK 4'h0
`define AFP_ACC_HI_BANK 4'hF
`define AFP_MEM_DEPTH   4096

// Reset values
`define AFP_ZERO8       8'h00
`define AFP_ZERO12      12'h000
`define AFP_ZERO16      16'h0000
`define AFP_ZERO32      32'h0000_0000

`endif

// ===== design/afp_pkg.sv
package afp_pkg;

    typedef enum logic [2:0]
    {
        st_idle,
        st_decode,
        st_read,
        st_process,
        st_write
    } afp_state_t;

    typedef struct packed
    {
        logic n;
        logic overflow_flag;
        logic z;
        logic digit_carry_flag;
        logic c;
    } afp_flags_t;

    typedef struct packed
    {
        logic [7:0] sum;
        afp_flags_t flags;
    } afp_alu_out_t;

endpackage

// ===== design/afp_mem_if.sv
interface afp_mem_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;

    modport core
    (
        output addr,
        output wdata,
        output we,
        input  rdata
    );

    modport mem
    (
        input  addr,
        input  wdata,
        input  we,
        output rdata
    );
endinterface

// ===== design/afp_alu.sv
`include "afp_cfg.svh"

module afp_alu
    import afp_pkg::*;
(
    input  wire logic [7:0] opnd_a,
    input  wire logic [7:0] opnd_b,
    output afp_alu_out_t    result
);

    logic [8:0] wide;
    logic [4:0] nib;

    always_comb
    begin
        wide = {1'b0, opnd_a} + {1'b0, opnd_b};
        nib  = {1'b0, opnd_a[`AFP_NIB_BITS]} + {1'b0, opnd_b[`AFP_NIB_BITS]};
        result.sum                    = wide[`AFP_BYTE_BITS];
        result.flags.c                = wide[`AFP_SUM_CARRY];
        result.flags.digit_carry_flag = nib[`AFP_NIB_CARRY];
        result.flags.z                = wide[`AFP_BYTE_BITS] == `AFP_ZERO8;
        result.flags.n                = wide[`AFP_SIGN];
        // Signed overflow: like signs in, other sign out
        result.flags.overflow_flag    =
            (opnd_a[`AFP_SIGN] == opnd_b[`AFP_SIGN])
            && (wide[`AFP_SIGN] != opnd_a[`AFP_SIGN]);
    end

endmodule

// ===== design/afp_dmem.sv
`include "afp_cfg.svh"

module afp_dmem
(
    input  wire logic clock,
    afp_mem_if.mem    port
);

    // Whole banked space; no reset, contents are software's business
    logic [7:0] store [0:`AFP_MEM_DEPTH-1];

    always_ff @(posedge clock)
    begin
        if (port.we)
        begin
            store[port.addr] <= port.wdata;
        end
    end

    assign port.rdata = store[port.addr];

endmodule

// ===== design/afp_core.sv
// Design decisions made here: the APB slave port and the register offsets.
`include "afp_cfg.svh"

module afp_core
    import afp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////
    logic [1:0]   rst_pipe;
    logic         rst_sync_n;
    logic         ctrl_ext;
    logic         next_ctrl_ext;
    logic [3:0]   bank;
    logic [3:0]   next_bank;
    logic [7:0]   accum;
    logic [7:0]   next_accum;
    afp_flags_t   flags;
    afp_flags_t   next_flags;
    logic         bad_op;
    logic         next_bad_op;
    logic [15:0]  instr;
    logic [15:0]  next_instr;
    logic [11:0]  index_base;
    logic [11:0]  next_index_base;
    logic [11:0]  maddr;
    logic [11:0]  next_maddr;
    afp_state_t   state;
    afp_state_t   next_state;
    logic         op_reg;
    logic         next_op_reg;
    logic         op_dest;
    logic         next_op_dest;
    logic [7:0]   op_w;
    logic [7:0]   next_op_w;
    logic [7:0]   op_b;
    logic [7:0]   next_op_b;
    logic [11:0]  eff_addr;
    logic [11:0]  next_eff_addr;
    afp_alu_out_t result;
    afp_alu_out_t next_result;
    afp_alu_out_t alu_out;
    logic         busy;
    logic         acc_ok;
    logic         wr;
    logic [8:0]   chk_sum;

    afp_mem_if mem_bus ();

    afp_dmem u_dmem
    (
        .clock (clock),
        .port  (mem_bus.mem)
    );

    afp_alu u_alu
    (
        .opnd_a (op_w),
        .opnd_b (op_b),
        .result (alu_out)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic is_add_literal(input logic [15:0] w);
        return w[`AFP_OPC_LIT_BITS] == `AFP_OPC_ADDL;
    endfunction

    function automatic logic is_add_register(input logic [15:0] w);
        return w[`AFP_OPC_REG_BITS] == `AFP_OPC_ADDF;
    endfunction

    function automatic logic is_indexed(input logic [15:0] w,
                                        input logic ext);
        return !w[`AFP_BIT_A] && ext
            && (w[`AFP_BYTE_BITS] <= `AFP_IDX_LIMIT);
    endfunction

    function automatic logic known_offset(input logic [11:0] a);
        return a == `AFP_OFF_CTRL || a == `AFP_OFF_BANK
            || a == `AFP_OFF_ACCUM || a == `AFP_OFF_STATUS
            || a == `AFP_OFF_INSTR || a == `AFP_OFF_INDEX
            || a == `AFP_OFF_MADDR || a == `AFP_OFF_MDATA;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rst_pipe <= '0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end

    assign rst_sync_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////
    // Bus stalls while an instruction runs, so no register moves under it
    assign busy    = state != st_idle;
    assign pready  = !busy;
    assign acc_ok  = psel && penable && pready;
    assign wr      = acc_ok && pwrite;
    assign pslverr = acc_ok && !known_offset(paddr);

    always_comb
    begin
        prdata = `AFP_ZERO32;
        case (paddr)
            `AFP_OFF_CTRL:   prdata[`AFP_CTRL_EXT] = ctrl_ext;
            `AFP_OFF_BANK:   prdata = 32'(bank);
            `AFP_OFF_ACCUM:  prdata = 32'(accum);
            `AFP_OFF_STATUS:
            begin
                prdata[`AFP_STAT_C]     = flags.c;
                prdata[`AFP_STAT_DC]    = flags.digit_carry_flag;
                prdata[`AFP_STAT_Z]     = flags.z;
                prdata[`AFP_STAT_OV]    = flags.overflow_flag;
                prdata[`AFP_STAT_N]     = flags.n;
                prdata[`AFP_STAT_BUSY]  = busy;
                prdata[`AFP_STAT_BADOP] = bad_op;
            end
            `AFP_OFF_INSTR:  prdata = 32'(instr);
            `AFP_OFF_INDEX:  prdata = 32'(index_base);
            `AFP_OFF_MADDR:  prdata = 32'(maddr);
            `AFP_OFF_MDATA:  prdata = 32'(mem_bus.rdata);
            default:         prdata = `AFP_ZERO32;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_ctrl_ext   = ctrl_ext;
        next_bank       = bank;
        next_accum      = accum;
        next_flags      = flags;
        next_bad_op     = bad_op;
        next_instr      = instr;
        next_index_base = index_base;
        next_maddr      = maddr;
        next_state      = state;
        next_op_reg     = op_reg;
        next_op_dest    = op_dest;
        next_op_w       = op_w;
        next_op_b       = op_b;
        next_eff_addr   = eff_addr;
        next_result     = result;
        mem_bus.addr    = busy ? eff_addr : maddr;
        mem_bus.wdata   = busy ? result.sum : pwdata[`AFP_BYTE_BITS];
        mem_bus.we      = !busy && wr && paddr == `AFP_OFF_MDATA;
        case (state)
            st_idle:
            begin
                if (wr)
                begin
                    case (paddr)
                        `AFP_OFF_CTRL:  next_ctrl_ext = pwdata[`AFP_CTRL_EXT];
                        `AFP_OFF_BANK:  next_bank = pwdata[`AFP_BANK_BITS];
                        `AFP_OFF_ACCUM: next_accum = pwdata[`AFP_BYTE_BITS];
                        `AFP_OFF_INDEX: next_index_base = pwdata[`AFP_ADDR_BITS];
                        `AFP_OFF_MADDR: next_maddr = pwdata[`AFP_ADDR_BITS];
                        `AFP_OFF_INSTR:
                        begin
                            // Unknown opcodes are flagged and not run
                            next_instr  = pwdata[`AFP_WORD_BITS];
                            next_bad_op = !(is_add_literal(next_instr)
                                || is_add_register(next_instr));
                            if (!next_bad_op)
                                next_state = st_decode;
                        end
                        default:        next_state = st_idle;
                    endcase
                end
            end
            st_decode:
            begin
                next_op_reg  = is_add_register(instr);
                next_op_dest = instr[`AFP_BIT_D];
                next_op_w    = accum;
                if (is_indexed(instr, ctrl_ext))
                    next_eff_addr = 12'(index_base
                        + 12'(instr[`AFP_BYTE_BITS]));
                else if (instr[`AFP_BIT_A])
                    next_eff_addr = {bank, instr[`AFP_BYTE_BITS]};
                else if (instr[`AFP_BYTE_BITS] < `AFP_ACC_SPLIT)
                    next_eff_addr = {`AFP_ACC_LO_BANK,
                        instr[`AFP_BYTE_BITS]};
                else
                    next_eff_addr = {`AFP_ACC_HI_BANK,
                        instr[`AFP_BYTE_BITS]};
                next_state = st_read;
            end
            st_read:
            begin
                next_op_b  = op_reg ? mem_bus.rdata
                    : instr[`AFP_BYTE_BITS];
                next_state = st_process;
            end
            st_process:
            begin
                next_result = alu_out;
                next_state  = st_write;
            end
            st_write:
            begin
                if (op_reg && op_dest)
                    mem_bus.we = 1'b1;
                else
                    next_accum = result.sum;
                next_flags = result.flags;
                next_state = st_idle;
            end
            default:
            begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_ext   <= 1'b0;
            bank       <= '0;
            accum      <= `AFP_ZERO8;
            flags      <= '0;
            bad_op     <= 1'b0;
            instr      <= `AFP_ZERO16;
            index_base <= `AFP_ZERO12;
            maddr      <= `AFP_ZERO12;
            state      <= st_idle;
            op_reg     <= 1'b0;
            op_dest    <= 1'b0;
            op_w       <= `AFP_ZERO8;
            op_b       <= `AFP_ZERO8;
            eff_addr   <= `AFP_ZERO12;
            result     <= '0;
        end
        else
        begin
            ctrl_ext   <= next_ctrl_ext;
            bank       <= next_bank;
            accum      <= next_accum;
            flags      <= next_flags;
            bad_op     <= next_bad_op;
            instr      <= next_instr;
            index_base <= next_index_base;
            maddr      <= next_maddr;
            state      <= next_state;
            op_reg     <= next_op_reg;
            op_dest    <= next_op_dest;
            op_w       <= next_op_w;
            op_b       <= next_op_b;
            eff_addr   <= next_eff_addr;
            result     <= next_result;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Independent reference sum, kept apart from the adder
    assign chk_sum = {1'b0, op_w} + {1'b0, op_b};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    literal_sum_a: assert property (
        (state == st_write && !op_reg)
        |=> accum == chk_sum[`AFP_BYTE_BITS])
        else $error("literal add result wrong");

    reg_operand_a: assert property (
        (state == st_read && op_reg) |=> op_b == $past(mem_bus.rdata))
        else $error("register operand not taken from memory");

    dest_accum_a: assert property (
        (state == st_write && op_reg && !op_dest)
        |-> !mem_bus.we ##1 accum == chk_sum[`AFP_BYTE_BITS])
        else $error("sum not placed in accumulator only");

    dest_register_a: assert property (
        (state == st_write && op_reg && op_dest)
        |-> mem_bus.we && mem_bus.addr == eff_addr
            && mem_bus.wdata == chk_sum[`AFP_BYTE_BITS]
            ##1 accum == $past(accum))
        else $error("sum not written back to register");

    access_bank_a: assert property (
        (state == st_decode && is_add_register(instr)
            && !instr[`AFP_BIT_A] && !is_indexed(instr, ctrl_ext))
        |=> eff_addr[`AFP_BANK_FIELD] ==
            ((instr[`AFP_BYTE_BITS] < `AFP_ACC_SPLIT)
                ? `AFP_ACC_LO_BANK : `AFP_ACC_HI_BANK))
        else $error("fast-access bank mapping wrong");

    banked_addr_a: assert property (
        (state == st_decode && is_add_register(instr)
            && instr[`AFP_BIT_A])
        |=> eff_addr == {bank, instr[`AFP_BYTE_BITS]})
        else $error("bank select not used");

    indexed_addr_a: assert property (
        (state == st_decode && is_add_register(instr)
            && is_indexed(instr, ctrl_ext))
        |=> eff_addr == 12'(index_base + 12'(instr[`AFP_BYTE_BITS])))
        else $error("indexed offset address wrong");

    four_phase_a: assert property (
        (state == st_decode) |=> state == st_read ##1 state == st_process
            ##1 state == st_write ##1 state == st_idle)
        else $error("instruction phases out of order");

    flag_update_a: assert property (
        (state == st_write)
        |=> flags.c == chk_sum[`AFP_SUM_CARRY]
            && flags.z == (chk_sum[`AFP_BYTE_BITS] == `AFP_ZERO8)
            && flags.n == chk_sum[`AFP_SIGN])
        else $error("status flags not updated from sum");

endmodule

// ===== tb/afp_core_tb.sv
`include "afp_cfg.svh"

module afp_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          err_total;
    int          cmp_count;
    logic [31:0] rd_val;
    logic        rd_err;
    logic [7:0]  lit_acc [5] = '{8'h10, 8'hFF, 8'h7F, 8'h80, 8'h0F};
    logic [7:0]  lit_k   [5] = '{8'h15, 8'h01, 8'h01, 8'h80, 8'h01};

    afp_core DUT
    (
        .clock   (clock),
        .rstn    (rstn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    always #50 clock = ~clock;

////////////////////////////////////////////////////////////////////////////////

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pready and read data are taken at the rising edge that completes
    // the access; the request stands unchanged until that edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        if (n >= 100)
            chk({31'h0, pready}, 32'h0000_0001);
        rd_val = prdata;
        rd_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_val, exp);
        chk({31'h0, rd_err}, 32'h0000_0000);
    endtask

    // Flags worked out from the sum, independent of the design's ALU
    function automatic logic [31:0] exp_stat(input logic [7:0] a,
                                             input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        exp_stat = 32'h0000_0000;
        exp_stat[`AFP_STAT_C]  = s[8];
        exp_stat[`AFP_STAT_DC] = h[4];
        exp_stat[`AFP_STAT_Z]  = (s[7:0] == 8'h00);
        exp_stat[`AFP_STAT_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        exp_stat[`AFP_STAT_N]  = s[7];
    endfunction

////////////////////////////////////////////////////////////////////////////////

    task t_reset;
        rd_chk(`AFP_OFF_CTRL, 32'h0000_0000);
        rd_chk(`AFP_OFF_BANK, 32'h0000_0000);
        rd_chk(`AFP_OFF_ACCUM, 32'h0000_0000);
        rd_chk(`AFP_OFF_STATUS, 32'h0000_0000);
        rd_chk(`AFP_OFF_INDEX, 32'h0000_0000);
        wr(`AFP_OFF_STATUS, 32'h0000_031F);
        rd_chk(`AFP_OFF_STATUS, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({31'h0, rd_err}, 32'h0000_0001);
        $display("test reset done");
    endtask

    task t_lit;
        logic [7:0] s;
        for (int i = 0; i < 5; i++)
        begin
            s = lit_acc[i] + lit_k[i];
            wr(`AFP_OFF_ACCUM, {24'h0, lit_acc[i]});
            wr(`AFP_OFF_INSTR, {16'h0, 8'h0F, lit_k[i]});
            rd_chk(`AFP_OFF_ACCUM, {24'h0, s});
            rd_chk(`AFP_OFF_STATUS, exp_stat(lit_acc[i], lit_k[i]));
        end
        $display("test literal add done");
    endtask

    // Each case uses a fresh address, so a wrong resolution reads junk
    task t_reg(input logic d, input logic a, input logic ext,
               input logic [3:0] bank, input logic [11:0] idx,
               input logic [7:0] f, input logic [7:0] acc,
               input logic [7:0] mval, input logic [11:0] ea);
        logic [7:0] s;
        s = acc + mval;
        wr(`AFP_OFF_CTRL, {31'h0, ext});
        wr(`AFP_OFF_BANK, {28'h0, bank});
        wr(`AFP_OFF_INDEX, {20'h0, idx});
        wr(`AFP_OFF_MADDR, {20'h0, ea});
        wr(`AFP_OFF_MDATA, {24'h0, mval});
        wr(`AFP_OFF_ACCUM, {24'h0, acc});
        wr(`AFP_OFF_INSTR, {16'h0, 6'h09, d, a, f});
        rd_chk(`AFP_OFF_STATUS, exp_stat(acc, mval));
        rd_chk(`AFP_OFF_ACCUM, {24'h0, d ? acc : s});
        rd_chk(`AFP_OFF_MDATA, {24'h0, d ? s : mval});
        $display("test register add f=%h done", f);
    endtask

    task t_timing;
        int lows;
        lows = 0;
        wr(`AFP_OFF_ACCUM, 32'h0000_0010);
        wr(`AFP_OFF_INSTR, 32'h0000_0F15);
        repeat (6)
        begin
            @(negedge clock);
            if (pready === 1'b0)
                lows++;
        end
        chk(lows, 32'h0000_0004);
        rd_chk(`AFP_OFF_ACCUM, 32'h0000_0025);
        wr(`AFP_OFF_INSTR, 32'h0000_1234);
        rd_chk(`AFP_OFF_ACCUM, 32'h0000_0025);
        rd_chk(`AFP_OFF_STATUS, 32'h0000_0200);
        $display("test timing done");
    endtask

    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        clock     = 1'b0;
        rstn      = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        err_total = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset;
        t_timing;
        t_lit;
        t_reg(1'b0, 1'b1, 1'b0, 4'h2, 12'h000, 8'h34, 8'h17, 8'hC2,
              12'h234);
        t_reg(1'b1, 1'b1, 1'b0, 4'h5, 12'h000, 8'h99, 8'h17, 8'hC2,
              12'h599);
        t_reg(1'b1, 1'b0, 1'b0, 4'h7, 12'h000, 8'h10, 8'h01, 8'h05,
              12'h010);
        t_reg(1'b0, 1'b0, 1'b0, 4'h7, 12'h000, 8'h80, 8'h80, 8'h80,
              12'hF80);
        t_reg(1'b1, 1'b0, 1'b1, 4'h7, 12'h300, 8'h05, 8'h02, 8'h40,
              12'h305);
        t_reg(1'b1, 1'b0, 1'b1, 4'h7, 12'h300, 8'h5F, 8'h0F, 8'h01,
              12'h35F);
        t_reg(1'b1, 1'b0, 1'b1, 4'h7, 12'h300, 8'h60, 8'h7F, 8'h7F,
              12'hF60);
        t_reg(1'b1, 1'b1, 1'b1, 4'h4, 12'h300, 8'h06, 8'hFF, 8'hFF,
              12'h406);
        stop_test;
    end

    // Whole run is well under a thousand cycles; this cuts a hang short
    initial
    begin
        #1000000;
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test;
    end

endmodule
